// ==== debug_cmd_consts.vh ====
// Constants for the debug-mode command engine.
// Assumes inclusion by bare name from design files in the same folder.
`ifndef DEBUG_CMD_CONSTS_VH
`define DEBUG_CMD_CONSTS_VH

// ----------------------------------------
// Status codes returned in each shift
// ----------------------------------------
`define ST_NON_DEBUG 2'b00
`define ST_IDLE 2'b01
`define ST_BUSY 2'b10
`define ST_VALID 2'b11

// ----------------------------------------
// Host command bytes
// ----------------------------------------
`define CMD_GROUP 4'h2
`define OP_NOP 8'h20
`define OP_READ_MAP 8'h21
`define OP_READ_MEM 8'h22
`define OP_READ_STACK 8'h23
`define OP_WRITE_REG 8'h24
`define OP_WRITE_MEM 8'h25
`define OP_TRACE 8'h26
`define OP_RETURN 8'h27
`define OP_UNLOCK 8'h28
`define OP_READ_REG 8'h29

// ----------------------------------------
// Command field codes
// ----------------------------------------
`define CF_NONE 4'h0
`define CF_READ_MAP 4'h1
`define CF_READ_MEM 4'h2
`define CF_READ_STACK 4'h3
`define CF_WRITE_REG 4'h4
`define CF_WRITE_MEM 4'h5
`define CF_UNLOCK 4'h8
`define CF_READ_REG 4'h9

// ----------------------------------------
// Follow-on byte counts
// ----------------------------------------
`define FOLLOW_NONE 3'h0
`define FOLLOW_TWO 3'h2
`define FOLLOW_FOUR 3'h4

// ----------------------------------------
// ROM entry point and shift word
// ----------------------------------------
`define ROM_ENTRY_ADDR 16'h8010
`define SHIFT_WIDTH 10

// ----------------------------------------
// Register word indices (haddr[4:2])
// ----------------------------------------
`define REG_CONTROL 3'h0
`define REG_BUFFER 3'h1
`define REG_ADDRESS 3'h2
`define REG_DATA 3'h3
`define REG_SYSCTL 3'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTL_ROM_EN_BIT 4
`define CTL_IN_DEBUG_BIT 8
`define SC_ROM_DONE_BIT 0
`define SC_TXC_BIT 1

`endif

// ==== sync_2ff.v ====
// Two-flop synchroniser bank for pin-level inputs.
// Assumes inputs are levels from outside the clk_sys domain.
`default_nettype none

module sync_2ff #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_sys,
    input wire resetn,
    // Asynchronous levels in, synchronised levels out
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            reg meta_reg;
            reg stable_reg;
            // First stage feeds only the second stage
            always @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    meta_reg <= 1'b0;
                    stable_reg <= 1'b0;
                end else begin
                    meta_reg <= async_in[i];
                    stable_reg <= meta_reg;
                end
            end
            assign sync_out[i] = stable_reg;
        end
    endgenerate

endmodule

`default_nettype wire

// ==== debug_mode_command_engine.v ====
// Debug-mode command engine: TAP data shift, command decode, ROM hand-off.
// Assumes a single AHB-Lite master, TAP pins asynchronous to clk_sys,
// and a CPU that reacts to jump, step and resume pulses.
//
// Register access over AHB-Lite and the placing of the registers were decided locally.
`default_nettype none
`include "debug_cmd_consts.vh"

// Contract
// - Report idle status when ready for commands
// - Command byte decides follow-on count and targets
// - Execute only after all follow-on bytes, untimed
// - Set command field, enable ROM, jump, busy
// - Step and return handled without ROM
// - ROM reads command field to choose operation
// - ROM sets transfer flag; shift end clears
// - ROM sets done bit; engine clears it
// - Background commands pass; undefined codes ignored
// - Register map: no follow-ons, map code, jump
// - Memory read: address then count, low first
// - Stack read: address then count, low first
// - Stack address is highest; ROM pops descending
// - Register write: address then data, low first
// - Writing instruction pointer changes resume address
// - Valid output byte tagged with valid status
// - Trace: exit, one cycle, re-enter debug
// - Return: leave debug, resume in background
// - Memory write: address then data, low first
module debug_mode_command_engine (
    // System clock and reset
    input wire clk_sys,
    input wire resetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // TAP link pins
    input wire tck,
    input wire tdi,
    input wire tap_shift,
    input wire tap_debug_sel,
    output reg tdo,
    // CPU control
    input wire debug_enter,
    output reg rom_jump,
    output reg [15:0] rom_jump_addr,
    output reg rom_enable,
    output reg step_req,
    output reg resume_req,
    // Background command hand-off
    output reg bg_cmd_strobe,
    output reg [7:0] bg_cmd_byte
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------
    function [2:0] follow_count;
        input [7:0] op;
        begin
            case (op)
                `OP_READ_MEM, `OP_READ_STACK, `OP_WRITE_REG, `OP_WRITE_MEM:
                    follow_count = `FOLLOW_FOUR;
                `OP_READ_REG: follow_count = `FOLLOW_TWO;
                default: follow_count = `FOLLOW_NONE;
            endcase
        end
    endfunction

    function [3:0] field_code;
        input [7:0] op;
        begin
            case (op)
                `OP_READ_MAP: field_code = `CF_READ_MAP;
                `OP_READ_MEM: field_code = `CF_READ_MEM;
                `OP_READ_STACK: field_code = `CF_READ_STACK;
                `OP_WRITE_REG: field_code = `CF_WRITE_REG;
                `OP_WRITE_MEM: field_code = `CF_WRITE_MEM;
                `OP_UNLOCK: field_code = `CF_UNLOCK;
                `OP_READ_REG: field_code = `CF_READ_REG;
                default: field_code = `CF_NONE;
            endcase
        end
    endfunction

    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_COLLECT = 2'd1;
    localparam [1:0] S_BUSY = 2'd2;

    // ----------------------------------------
    // Pin synchronisation and edge detect
    // ----------------------------------------
    wire [3:0] pins_sync;
    reg tck_prev_reg;
    reg shift_prev_reg;

    sync_2ff #(
        .WIDTH(4)
    ) u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .async_in({tap_debug_sel, tap_shift, tdi, tck}),
        .sync_out(pins_sync)
    );

    wire tck_s = pins_sync[0];
    wire tdi_s = pins_sync[1];
    wire shift_s = pins_sync[2];
    wire armed_s = pins_sync[3];
    wire tck_rise = tck_s & ~tck_prev_reg;
    wire frame_start = shift_s & ~shift_prev_reg;
    wire frame_end = ~shift_s & shift_prev_reg;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tck_prev_reg <= 1'b0;
            shift_prev_reg <= 1'b0;
        end else begin
            tck_prev_reg <= tck_s;
            shift_prev_reg <= shift_s;
        end
    end

    // ----------------------------------------
    // Engine state
    // ----------------------------------------
    reg [1:0] state_reg;
    reg [2:0] need_reg;
    reg [2:0] got_reg;
    reg [7:0] op_reg;
    reg [3:0] command_code_field;
    reg in_debug_reg;
    reg [15:0] debug_address_reg;
    reg [15:0] debug_data_reg;
    reg [7:0] debug_byte_buffer;
    reg [7:0] rx_byte_reg;
    reg transfer_complete_flag;
    reg rom_done_flag;
    reg [`SHIFT_WIDTH-1:0] shift_reg;
    reg [1:0] status_code;

    // ----------------------------------------
    // AHB-Lite slave, zero wait states
    // ----------------------------------------
    reg wr_pend_reg;
    reg [2:0] wr_idx_reg;
    wire ahb_take = hsel & htrans[1] & hready;
    wire [2:0] a_idx = haddr[4:2];
    wire a_mapped = (haddr[31:5] == 27'h0) & (a_idx <= `REG_SYSCTL);
    wire wr_buffer = wr_pend_reg & (wr_idx_reg == `REG_BUFFER);
    wire wr_sysctl = wr_pend_reg & (wr_idx_reg == `REG_SYSCTL);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg <= 3'h0;
            hrdata <= 32'h0;
        end else begin
            wr_pend_reg <= ahb_take & hwrite & a_mapped;
            wr_idx_reg <= a_idx;
            if (ahb_take & ~hwrite) begin
                case (a_mapped ? a_idx : 3'h7)
                    `REG_CONTROL: hrdata <= {23'h0, in_debug_reg, 3'h0, rom_enable,
                                             command_code_field};
                    `REG_BUFFER: hrdata <= {24'h0, rx_byte_reg};
                    `REG_ADDRESS: hrdata <= {16'h0, debug_address_reg};
                    `REG_DATA: hrdata <= {16'h0, debug_data_reg};
                    `REG_SYSCTL: hrdata <= {30'h0, transfer_complete_flag, rom_done_flag};
                    default: hrdata <= 32'h0;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Status code
    // ----------------------------------------
    always @* begin
        if (!in_debug_reg) begin
            status_code = `ST_NON_DEBUG;
        end else if (state_reg == S_BUSY) begin
            status_code = transfer_complete_flag ? `ST_VALID : `ST_BUSY;
        end else begin
            status_code = `ST_IDLE;
        end
    end

    // ----------------------------------------
    // TAP data shift
    // ----------------------------------------
    // Status in low bits, byte above; tdi enters at the top
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shift_reg <= {`SHIFT_WIDTH{1'b0}};
            tdo <= 1'b0;
        end else begin
            if (frame_start) begin
                shift_reg <= {debug_byte_buffer, status_code};
            end else if (shift_s & tck_rise) begin
                shift_reg <= {tdi_s, shift_reg[`SHIFT_WIDTH-1:1]};
            end
            tdo <= frame_start ? status_code[0] : shift_reg[0];
        end
    end

    // ----------------------------------------
    // Flags shared with the ROM
    // ----------------------------------------
    // Set by software wins over clear by the engine
    wire done_seen = (state_reg == S_BUSY) & rom_done_flag;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            transfer_complete_flag <= 1'b0;
            rom_done_flag <= 1'b0;
            debug_byte_buffer <= 8'h0;
        end else begin
            if (wr_buffer) begin
                debug_byte_buffer <= hwdata[7:0];
                transfer_complete_flag <= 1'b1;
            end else if (frame_end) begin
                transfer_complete_flag <= 1'b0;
            end
            if (wr_sysctl & hwdata[`SC_ROM_DONE_BIT]) begin
                rom_done_flag <= 1'b1;
            end else if (done_seen) begin
                rom_done_flag <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Command decode and collection
    // ----------------------------------------
    wire [7:0] rx_now = shift_reg[`SHIFT_WIDTH-1:2];
    wire byte_in = frame_end & armed_s & in_debug_reg;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
            need_reg <= 3'h0;
            got_reg <= 3'h0;
            op_reg <= 8'h0;
            command_code_field <= `CF_NONE;
            in_debug_reg <= 1'b0;
            debug_address_reg <= 16'h0;
            debug_data_reg <= 16'h0;
            rx_byte_reg <= 8'h0;
            rom_jump <= 1'b0;
            rom_jump_addr <= `ROM_ENTRY_ADDR;
            rom_enable <= 1'b0;
            step_req <= 1'b0;
            resume_req <= 1'b0;
            bg_cmd_strobe <= 1'b0;
            bg_cmd_byte <= 8'h0;
        end else begin
            rom_jump <= 1'b0;
            step_req <= 1'b0;
            resume_req <= 1'b0;
            bg_cmd_strobe <= 1'b0;
            if (debug_enter) begin
                in_debug_reg <= 1'b1;
            end
            if (frame_end) begin
                rx_byte_reg <= rx_now;
            end
            if (wr_pend_reg & (wr_idx_reg == `REG_ADDRESS)) begin
                debug_address_reg <= hwdata[15:0];
            end
            if (wr_pend_reg & (wr_idx_reg == `REG_DATA)) begin
                debug_data_reg <= hwdata[15:0];
            end
            if (!armed_s) begin
                state_reg <= S_IDLE;
                got_reg <= 3'h0;
                need_reg <= 3'h0;
            end else begin
                case (state_reg)
                    S_IDLE: begin
                        if (byte_in) begin
                            op_reg <= rx_now;
                            need_reg <= follow_count(rx_now);
                            got_reg <= 3'h0;
                            if (rx_now[7:4] != `CMD_GROUP) begin
                                bg_cmd_strobe <= 1'b1;
                                bg_cmd_byte <= rx_now;
                            end else if (rx_now == `OP_TRACE) begin
                                step_req <= 1'b1;
                                in_debug_reg <= 1'b0;
                            end else if (rx_now == `OP_RETURN) begin
                                resume_req <= 1'b1;
                                in_debug_reg <= 1'b0;
                            end else if (field_code(rx_now) == `CF_NONE) begin
                                state_reg <= S_IDLE;
                            end else if (follow_count(rx_now) == `FOLLOW_NONE) begin
                                command_code_field <= field_code(rx_now);
                                rom_enable <= 1'b1;
                                rom_jump <= 1'b1;
                                rom_jump_addr <= `ROM_ENTRY_ADDR;
                                state_reg <= S_BUSY;
                            end else begin
                                state_reg <= S_COLLECT;
                            end
                        end
                    end
                    S_COLLECT: begin
                        if (byte_in) begin
                            // Address low, address high, data low, data high
                            case (got_reg)
                                3'h0: debug_address_reg[7:0] <= rx_now;
                                3'h1: debug_address_reg[15:8] <= rx_now;
                                3'h2: debug_data_reg[7:0] <= rx_now;
                                default: debug_data_reg[15:8] <= rx_now;
                            endcase
                            got_reg <= got_reg + 3'h1;
                            if (got_reg + 3'h1 == need_reg) begin
                                command_code_field <= field_code(op_reg);
                                rom_enable <= 1'b1;
                                rom_jump <= 1'b1;
                                rom_jump_addr <= `ROM_ENTRY_ADDR;
                                state_reg <= S_BUSY;
                            end
                        end
                    end
                    S_BUSY: begin
                        // Extra host bytes reach the ROM through the buffer register
                        if (done_seen) begin
                            state_reg <= S_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= S_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ==== debug_cmd_engine_sva.sv ====
// Port assertions for the debug-mode command engine.
// Assumes a bind onto the engine's top module; link pins are host levels.
`default_nettype none
module debug_cmd_engine_sva (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Link pins
    input wire logic tap_shift,
    input wire logic tap_debug_sel,
    // Engine outputs
    input wire logic rom_jump,
    input wire logic [15:0] rom_jump_addr,
    input wire logic rom_enable,
    input wire logic step_req,
    input wire logic resume_req,
    input wire logic bg_cmd_strobe,
    input wire logic [7:0] bg_cmd_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence s_jump_issued;
        rom_jump && rom_jump_addr == 16'h8010;
    endsequence
    sequence s_jump_settled;
        !rom_jump && rom_enable;
    endsequence
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_jump_seq;
        rom_jump |-> s_jump_issued ##1 s_jump_settled;
    endproperty
    property p_enable_sticky;
        rom_enable |=> rom_enable;
    endproperty
    property p_jump_after_frame;
        rom_jump |-> !tap_shift && !$past(tap_shift);
    endproperty
    property p_step_alone;
        step_req |-> !rom_jump && !resume_req;
    endproperty
    property p_step_pulse;
        step_req |=> !step_req;
    endproperty
    property p_resume_alone;
        resume_req |-> !rom_jump ##1 !resume_req;
    endproperty
    property p_bg_group;
        bg_cmd_strobe |-> bg_cmd_byte[7:4] != 4'h2;
    endproperty
    property p_disarmed;
        !tap_debug_sel [*4] |-> !(rom_jump || step_req || resume_req);
    endproperty
    a_jump_seq: assert property (p_jump_seq)
        else $error("jump without entry address or rom enable");
    a_enable_sticky: assert property (p_enable_sticky)
        else $error("rom enable dropped");
    a_jump_after_frame: assert property (p_jump_after_frame)
        else $error("jump inside a frame");
    a_step_alone: assert property (p_step_alone)
        else $error("step together with rom jump or resume");
    a_step_pulse: assert property (p_step_pulse)
        else $error("step request longer than one cycle");
    a_resume_alone: assert property (p_resume_alone)
        else $error("resume with jump or too long");
    a_bg_group: assert property (p_bg_group)
        else $error("debug group byte passed as background");
    a_disarmed: assert property (p_disarmed)
        else $error("action while engine disarmed");
endmodule
`default_nettype wire

// ==== tap_host_model.sv ====
// Host model on the TAP link: one byte per frame, returns the tdo word.
// Assumes the engine samples these pins with its own faster clock.
`default_nettype none
module tap_host_model (
    // Link pins driven by the host
    output logic tck,
    output logic tdi,
    output logic tap_shift,
    output logic tap_debug_sel,
    // Serial data from the engine
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 80;
    initial begin
        tck = 1'b0;
        tdi = 1'b1;
        tap_shift = 1'b0;
        tap_debug_sel = 1'b1;
    end
    // Clock stands still between frames
    task automatic xfer(input logic [7:0] b, output logic [9:0] seen);
        logic [9:0] word;
        word = {b, 2'b00};
        // Keep pin changes off the clock edge
        #2;
        tap_shift = 1'b1;
        #(HALF);
        for (int i = 0; i < 10; i++) begin
            tdi = word[i];
            #(HALF);
            seen[i] = tdo;
            tck = 1'b1;
            #(HALF);
            tck = 1'b0;
        end
        #(HALF);
        tap_shift = 1'b0;
        tdi = ~tdi; // Last bit inverted, no stale level
        #(2 * HALF);
    endtask
    // Reload of the debug instruction
    task automatic rearm();
        tap_debug_sel = 1'b0;
        #(2 * HALF);
        tap_debug_sel = 1'b1;
        #(2 * HALF);
    endtask
endmodule
`default_nettype wire

// ==== debug_mode_command_engine_tb.sv ====
// Bench for the debug-mode command engine: AHB-Lite master plus TAP host.
// Assumes hready is fed back from hreadyout (single slave).
`default_nettype none
`include "debug_cmd_consts.vh"
module debug_mode_command_engine_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic debug_enter = 1'b0;
    wire hreadyout, hresp, tck, tdi, tap_shift, tap_debug_sel, tdo;
    wire rom_jump, rom_enable, step_req, resume_req, bg_cmd_strobe;
    wire [31:0] hrdata;
    wire [15:0] rom_jump_addr;
    wire [7:0] bg_cmd_byte;
    int err_count = 0;
    int n_compared = 0;
    int n_jump = 0;
    int n_step = 0;
    int n_resume = 0;
    logic [7:0] last_bg = 8'h0;
    logic [31:0] rd;
    logic [9:0] w;
    always #4 clk_sys = ~clk_sys;
    debug_mode_command_engine uut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .tck(tck), .tdi(tdi), .tap_shift(tap_shift), .tap_debug_sel(tap_debug_sel),
        .tdo(tdo), .debug_enter(debug_enter), .rom_jump(rom_jump),
        .rom_jump_addr(rom_jump_addr), .rom_enable(rom_enable), .step_req(step_req),
        .resume_req(resume_req), .bg_cmd_strobe(bg_cmd_strobe), .bg_cmd_byte(bg_cmd_byte));
    tap_host_model host (.tck(tck), .tdi(tdi), .tap_shift(tap_shift),
        .tap_debug_sel(tap_debug_sel), .tdo(tdo));
    always @(posedge clk_sys) begin
        if (rom_jump === 1'b1) n_jump++;
        if (step_req === 1'b1) n_step++;
        if (resume_req === 1'b1) n_resume++;
        if (bg_cmd_strobe === 1'b1) last_bg <= bg_cmd_byte;
    end
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #400000;
        err_count++;
        conclude();
    end
    // ----------------------------------------
    // Bus and link tasks
    // ----------------------------------------
    task automatic wait_ready();
        int k;
        k = 0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1 && k < 16) begin
            @(posedge clk_sys);
            k++;
        end
        if (hreadyout !== 1'b1) begin
            err_count++;
            conclude();
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        r = hrdata;
        check(hresp, 1'b0);
    endtask
    task automatic enter_debug();
        @(posedge clk_sys);
        debug_enter <= 1'b1;
        @(posedge clk_sys);
        debug_enter <= 1'b0;
    endtask
    // Command with four follow-on bytes, address then data, low first
    task automatic run_cmd(input logic [7:0] op, input logic [3:0] code,
        input logic [15:0] a, input logic [15:0] d);
        int j0;
        j0 = n_jump;
        host.xfer(op, w);
        host.xfer(a[7:0], w);
        host.xfer(a[15:8], w);
        host.xfer(d[7:0], w);
        check(32'(n_jump), 32'(j0));
        host.xfer(d[15:8], w);
        check(32'(n_jump), 32'(j0 + 1));
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd[8:0], {1'b1, 3'h0, 1'b1, code});
        ahb(1'b0, 32'h8, 32'h0, rd);
        check(rd[15:0], a);
        ahb(1'b0, 32'hc, 32'h0, rd);
        check(rd[15:0], d);
    endtask
    // ROM side: load a byte, see it valid, then signal done
    task automatic rom_reply(input logic [7:0] b);
        host.xfer(8'h00, w);
        check(w[1:0], `ST_BUSY);
        ahb(1'b1, 32'h4, {24'h0, b}, rd);
        ahb(1'b0, 32'h10, 32'h0, rd);
        check(rd[1], 1'b1);
        host.xfer(8'h00, w);
        check(w, {b, `ST_VALID});
        ahb(1'b0, 32'h10, 32'h0, rd);
        check(rd[1], 1'b0);
        ahb(1'b1, 32'h10, 32'h1, rd);
        ahb(1'b0, 32'h10, 32'h0, rd);
        check(rd[0], 1'b0);
        host.xfer(`OP_NOP, w);
        check(w[1:0], `ST_IDLE);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge clk_sys);
        check(rom_jump_addr, `ROM_ENTRY_ADDR);
        check(rom_enable, 1'b0);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        host.xfer(`OP_READ_MAP, w);
        check(w[1:0], `ST_NON_DEBUG);
        check(32'(n_jump), 32'h0);
        enter_debug();
        host.xfer(`OP_NOP, w);
        check(w[1:0], `ST_IDLE);
        host.xfer(8'h2f, w);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd, 32'h100);
        check(32'(n_jump), 32'h0);
        for (int i = 0; i < 4; i++) begin
            run_cmd(`OP_READ_MEM + i, `CF_READ_MEM + i, 16'h1234 + i, 16'hab01 << i);
            rom_reply(8'h5a ^ i);
        end
        host.xfer(`OP_READ_MAP, w);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd[3:0], `CF_READ_MAP);
        check(32'(n_jump), 32'h5);
        rom_reply(8'hb4);
        host.xfer(8'h55, w);
        check(last_bg, 8'h55);
        host.xfer(`OP_READ_MEM, w);
        host.xfer(8'h11, w);
        host.rearm();
        run_cmd(`OP_WRITE_REG, `CF_WRITE_REG, 16'h00f3, 16'hc0de);
        rom_reply(8'h0f);
        host.xfer(`OP_READ_REG, w);
        host.xfer(8'h34, w);
        host.xfer(8'h12, w);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd[3:0], `CF_READ_REG);
        ahb(1'b0, 32'h8, 32'h0, rd);
        check(rd[15:0], 16'h1234);
        rom_reply(8'h77);
        host.xfer(`OP_UNLOCK, w);
        check(w[1:0], `ST_IDLE);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd[3:0], `CF_UNLOCK);
        rom_reply(8'h3c);
        host.xfer(`OP_TRACE, w);
        check(32'(n_step), 32'h1);
        ahb(1'b0, 32'h0, 32'h0, rd);
        check(rd[8], 1'b0);
        enter_debug();
        host.xfer(`OP_RETURN, w);
        check(32'(n_resume), 32'h1);
        check(32'(n_jump), 32'h8);
        host.xfer(`OP_NOP, w);
        check(w[1:0], `ST_NON_DEBUG);
        conclude();
    end
endmodule
bind debug_mode_command_engine debug_cmd_engine_sva chk (.clk_sys(clk_sys), .resetn(resetn),
    .tap_shift(tap_shift), .tap_debug_sel(tap_debug_sel), .rom_jump(rom_jump),
    .rom_jump_addr(rom_jump_addr), .rom_enable(rom_enable), .step_req(step_req),
    .resume_req(resume_req), .bg_cmd_strobe(bg_cmd_strobe), .bg_cmd_byte(bg_cmd_byte));
`default_nettype wire
